// >>> src/lbc_pkg.sv
package lbc_pkg;

   // =========================================================================
   // Command encodings on {csN, rasN, casN, weN}.
   // =========================================================================
   localparam logic [3:0] CMD_NOP       = 4'h7;
   localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
   localparam logic [3:0] CMD_READ      = 4'h5;
   localparam logic [3:0] CMD_WRITE     = 4'h4;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_TERMINATE = 4'h6;
   localparam logic [3:0] CMD_REFRESH   = 4'h1;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   localparam logic [3:0] CMD_DESELECT  = 4'hF;

   // =========================================================================
   // Request codes on the user command port.
   // =========================================================================
   localparam logic [2:0] REQ_ACTIVATE  = 3'h0;
   localparam logic [2:0] REQ_READ      = 3'h1;
   localparam logic [2:0] REQ_WRITE     = 3'h2;
   localparam logic [2:0] REQ_PRECHARGE = 3'h3;
   localparam logic [2:0] REQ_PRE_ALL   = 3'h4;
   localparam logic [2:0] REQ_REFRESH   = 3'h5;
   localparam logic [2:0] REQ_MODE_LOAD = 3'h6;
   localparam logic [2:0] REQ_TERMINATE = 3'h7;

   // =========================================================================
   // Timing in nanoseconds and derived cycle counts at 50 MHz.
   // =========================================================================
   localparam int CLK_PERIOD_PS = 20000;
   localparam int T_RP_NS       = 30;
   localparam int T_RCD_NS      = 30;
   localparam int T_WR_NS       = 15;
   localparam int T_RFC_NS      = 110;
   localparam int T_MRD_NS      = 20;
   localparam int T_XP_NS       = 25;

   function automatic int nsToCyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : nsToCyc

   localparam int CYC_RP  = nsToCyc(T_RP_NS);
   localparam int CYC_RCD = nsToCyc(T_RCD_NS);
   localparam int CYC_WR  = nsToCyc(T_WR_NS);
   localparam int CYC_RFC = nsToCyc(T_RFC_NS);
   localparam int CYC_MRD = nsToCyc(T_MRD_NS);
   localparam int CYC_XP  = nsToCyc(T_XP_NS);

   // Burst length in clocks (two data beats per clock) and read latency.
   localparam int BURST_CYC = 2;
   localparam int READ_LAT  = 3;
   localparam int WRITE_END = 1 + BURST_CYC;

   localparam int CNT_W = 8;

   // Bank states, one-hot.
   typedef enum logic [6:0] {
      BK_IDLE    = 7'b0000001,
      BK_ACTING  = 7'b0000010,
      BK_ACTIVE  = 7'b0000100,
      BK_READ    = 7'b0001000,
      BK_WRITE   = 7'b0010000,
      BK_AUTOPRE = 7'b0100000,
      BK_PRECHG  = 7'b1000000
   } lbc_bank_t;

endpackage : lbc_pkg

// >>> src/lbc_bank.sv
`timescale 1ns/1ps
`default_nettype none
module lbc_bank
   import lbc_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             doActivate,
   input  wire logic             doRead,
   input  wire logic             doWrite,
   input  wire logic             doAutoPre,
   input  wire logic             doPrecharge,
   input  wire logic             doTerminate,
   output var  lbc_bank_t        state,
   output var  logic             accessPeriod
);

   logic [CNT_W-1:0] timer_r;    // Delay down-counter.
   logic [CNT_W-1:0] preDelay_r; // Cycles until precharge period of an AP burst.

   // =========================================================================
   // Per-bank state and delay counters.
   // =========================================================================
   // One state per bank, advanced by its own down-counters.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state      <= BK_IDLE;
         timer_r    <= '0;
         preDelay_r <= '0;
      end else begin
         if (timer_r != '0) timer_r <= timer_r - CNT_W'(1);
         if (preDelay_r != '0) preDelay_r <= preDelay_r - CNT_W'(1);
         if (doPrecharge) begin
            state   <= BK_PRECHG;
            timer_r <= CNT_W'(CYC_RP - 1);
         end else if (doActivate) begin
            state   <= BK_ACTING;
            timer_r <= CNT_W'(CYC_RCD - 1);
         end else if ((doRead || doWrite) && doAutoPre) begin
            state      <= BK_AUTOPRE;
            preDelay_r <= doRead ? CNT_W'(BURST_CYC - 1)
                                 : CNT_W'(WRITE_END + CYC_WR - 1);
            timer_r    <= doRead ? CNT_W'(BURST_CYC + CYC_RP - 1)
                                 : CNT_W'(WRITE_END + CYC_WR + CYC_RP - 1);
         end else if (doRead) begin
            state   <= BK_READ;
            timer_r <= CNT_W'(READ_LAT + BURST_CYC - 1);
         end else if (doWrite) begin
            state   <= BK_WRITE;
            timer_r <= CNT_W'(WRITE_END + CYC_WR - 1);
         end else if (doTerminate && state == BK_READ) begin
            state   <= BK_ACTIVE;
         end else if (timer_r <= CNT_W'(1)) begin
            unique case (state)
               BK_ACTING:  state <= BK_ACTIVE;
               BK_READ:    state <= BK_ACTIVE;
               BK_WRITE:   state <= BK_ACTIVE;
               BK_AUTOPRE: state <= BK_IDLE;
               BK_PRECHG:  state <= BK_IDLE;
               default:    state <= state;
            endcase
         end
      end
   end

   // Access period of an auto-precharge burst, before its precharge period.
   assign accessPeriod = (state == BK_AUTOPRE) && (preDelay_r != '0);

endmodule : lbc_bank
`default_nettype wire

// >>> src/lbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module lbc_host
   import lbc_pkg::*;
#(
   parameter int BANKS  = 4,
   parameter int ADDR_W = 13
)(
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                reqValid,
   input  wire logic [2:0]          reqCmd,
   input  wire logic [1:0]          reqBank,
   input  wire logic [ADDR_W-1:0]   reqAddr,
   input  wire logic                reqAutoPre,
   output logic                     reqReady,
   output logic                     reqReject,
   output logic                     memCke,
   output logic                     memCsN,
   output logic                     memRasN,
   output logic                     memCasN,
   output logic                     memWeN,
   output logic [1:0]               memBa,
   output logic [ADDR_W-1:0]        memAddr,
   output logic                     memDmMask
);

   // Elaboration checks: the bank select is two bits and address ten is used.
   if (BANKS != 4) begin : gBanksChk
      $error("lbc_host supports four banks only");
   end
   if (ADDR_W < 11) begin : gAddrChk
      $error("lbc_host needs address bit ten");
   end

   lbc_bank_t           bankState [BANKS];
   logic [BANKS-1:0]    bankAccess;
   logic [BANKS-1:0]    bankAct, bankRd, bankWr, bankPre;
   logic                issue, issueAutoPre, issueTerm;
   logic                legal;
   logic [CNT_W-1:0]    globalWait_r;  // Refresh / mode-load / precharge-all hold.
   logic [CNT_W-1:0]    ckeWait_r;     // Exit time after clock enable rises.
   logic                ckeEn_r;
   logic [1:0]          lastReadBank_r;
   logic                lastReadLive_r;
   logic [CNT_W-1:0]    readData_r;    // Cycles until read data finished.
   logic [CNT_W-1:0]    writeData_r;   // Cycles until write data finished.
   logic                allIdle;
   lbc_bank_t           tgt;
   logic                othersAccess;

   // =========================================================================
   // Per-bank trackers.
   // =========================================================================
   for (genvar b = 0; b < BANKS; b++) begin : gBank
      lbc_bank uBank (
         .ref_clk      (ref_clk),
         .rst          (rst),
         .doActivate   (bankAct[b]),
         .doRead       (bankRd[b]),
         .doWrite      (bankWr[b]),
         .doAutoPre    (issueAutoPre),
         .doPrecharge  (bankPre[b]),
         .doTerminate  (issueTerm && lastReadLive_r && lastReadBank_r == 2'(b)),
         .state        (bankState[b]),
         .accessPeriod (bankAccess[b])
      );
   end

   // =========================================================================
   // Legality check of the pending request.
   // =========================================================================
   // Every check below keeps the pins to the listed legal combinations.
   always_comb begin
      allIdle = 1'b1;
      othersAccess = 1'b0;
      for (int i = 0; i < BANKS; i++) begin
         if (bankState[i] != BK_IDLE) allIdle = 1'b0;
         if (i != int'(reqBank) && bankAccess[i]) othersAccess = 1'b1;
      end
      tgt   = bankState[reqBank];
      legal = 1'b0;
      if (ckeEn_r && globalWait_r == '0) begin
         unique case (reqCmd)
            REQ_ACTIVATE:  legal = (tgt == BK_IDLE);
            REQ_READ:      legal = (tgt == BK_ACTIVE || tgt == BK_READ ||
                                    tgt == BK_WRITE) && !othersAccess;
            REQ_WRITE:     legal = (tgt == BK_ACTIVE || tgt == BK_WRITE ||
                                    tgt == BK_READ) && !othersAccess
                                   && readData_r == '0;
            REQ_PRECHARGE: legal = (tgt == BK_ACTIVE || tgt == BK_READ ||
                                    tgt == BK_WRITE || tgt == BK_IDLE);
            REQ_PRE_ALL:   legal = 1'b1;
            REQ_REFRESH:   legal = allIdle && readData_r == '0 && writeData_r == '0;
            REQ_MODE_LOAD: legal = allIdle && readData_r == '0 && writeData_r == '0;
            REQ_TERMINATE: legal = lastReadLive_r && readData_r != '0;
            default:       legal = 1'b0;
         endcase
         // A bank activating, precharging or in auto precharge takes nothing.
         if (reqCmd == REQ_PRE_ALL) begin
            for (int i = 0; i < BANKS; i++) begin
               if (bankState[i] == BK_ACTING || bankState[i] == BK_AUTOPRE ||
                   bankState[i] == BK_PRECHG) legal = 1'b0;
            end
         end
      end
      // A request still held while its answer shows is the one just answered.
      issue        = reqValid && legal && !reqReady && !reqReject;
      issueAutoPre = issue && reqAutoPre &&
                     (reqCmd == REQ_READ || reqCmd == REQ_WRITE);
      issueTerm    = issue && reqCmd == REQ_TERMINATE;
      for (int i = 0; i < BANKS; i++) begin
         bankAct[i] = issue && reqCmd == REQ_ACTIVATE && reqBank == 2'(i);
         bankRd[i]  = issue && reqCmd == REQ_READ && reqBank == 2'(i);
         bankWr[i]  = issue && reqCmd == REQ_WRITE && reqBank == 2'(i);
         bankPre[i] = issue && ((reqCmd == REQ_PRECHARGE && reqBank == 2'(i)) ||
                      (reqCmd == REQ_PRE_ALL && bankState[i] != BK_IDLE));
      end
   end

   // =========================================================================
   // Clock enable and exit delay.
   // =========================================================================
   // Clock enable rises after reset; commands wait the exit time.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         memCke    <= 1'b0;
         ckeWait_r <= CNT_W'(CYC_XP);
         ckeEn_r   <= 1'b0;
      end else begin
         memCke <= 1'b1;
         if (memCke && ckeWait_r != '0) ckeWait_r <= ckeWait_r - CNT_W'(1);
         ckeEn_r <= memCke && ckeWait_r == '0;
      end
   end

   // =========================================================================
   // Global holds for refresh, mode load and precharge-all.
   // =========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         globalWait_r <= '0;
      end else if (issue && reqCmd == REQ_REFRESH) begin
         globalWait_r <= CNT_W'(CYC_RFC - 1);
      end else if (issue && reqCmd == REQ_MODE_LOAD) begin
         globalWait_r <= CNT_W'(CYC_MRD - 1);
      end else if (issue && reqCmd == REQ_PRE_ALL) begin
         globalWait_r <= CNT_W'(CYC_RP - 1);
      end else if (globalWait_r != '0) begin
         globalWait_r <= globalWait_r - CNT_W'(1);
      end
   end

   // =========================================================================
   // Data bus occupancy and most recent read.
   // =========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readData_r     <= '0;
         writeData_r    <= '0;
         lastReadBank_r <= '0;
         lastReadLive_r <= 1'b0;
         memDmMask      <= 1'b0;
      end else begin
         if (readData_r != '0) readData_r <= readData_r - CNT_W'(1);
         if (writeData_r != '0) writeData_r <= writeData_r - CNT_W'(1);
         if (issue && reqCmd == REQ_READ) begin
            readData_r     <= CNT_W'(READ_LAT + BURST_CYC - 1);
            lastReadBank_r <= reqBank;
            lastReadLive_r <= !reqAutoPre;
         end else if (issueTerm) begin
            readData_r     <= '0;
            lastReadLive_r <= 1'b0;
         end
         if (issue && reqCmd == REQ_WRITE) writeData_r <= CNT_W'(WRITE_END);
         // Mask remaining write beats when a read cuts in.
         memDmMask <= (issue && reqCmd == REQ_READ && writeData_r > CNT_W'(1)) ||
                      (memDmMask && writeData_r > CNT_W'(1));
      end
   end

   // =========================================================================
   // Command pins, registered so they are stable at the device edge.
   // =========================================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {memCsN, memRasN, memCasN, memWeN} <= CMD_DESELECT;
         memBa     <= '0;
         memAddr   <= '0;
         reqReady  <= 1'b0;
         reqReject <= 1'b0;
      end else begin
         reqReady  <= issue;
         reqReject <= reqValid && !legal && !reqReady && !reqReject;
         memBa     <= reqBank;
         memAddr   <= reqAddr;
         {memCsN, memRasN, memCasN, memWeN} <= CMD_NOP;
         if (issue) begin
            unique case (reqCmd)
               REQ_ACTIVATE:  {memCsN, memRasN, memCasN, memWeN} <= CMD_ACTIVATE;
               REQ_READ:      {memCsN, memRasN, memCasN, memWeN} <= CMD_READ;
               REQ_WRITE:     {memCsN, memRasN, memCasN, memWeN} <= CMD_WRITE;
               REQ_PRECHARGE: {memCsN, memRasN, memCasN, memWeN} <= CMD_PRECHARGE;
               REQ_PRE_ALL:   {memCsN, memRasN, memCasN, memWeN} <= CMD_PRECHARGE;
               REQ_REFRESH:   {memCsN, memRasN, memCasN, memWeN} <= CMD_REFRESH;
               REQ_MODE_LOAD: {memCsN, memRasN, memCasN, memWeN} <= CMD_MODE_LOAD;
               REQ_TERMINATE: {memCsN, memRasN, memCasN, memWeN} <= CMD_TERMINATE;
               default:       {memCsN, memRasN, memCasN, memWeN} <= CMD_NOP;
            endcase
            // Address ten carries auto precharge or the all-banks select.
            if (reqCmd == REQ_READ || reqCmd == REQ_WRITE) memAddr[10] <= reqAutoPre;
            if (reqCmd == REQ_PRECHARGE) memAddr[10] <= 1'b0;
            if (reqCmd == REQ_PRE_ALL) memAddr[10] <= 1'b1;
         end
      end
   end

endmodule : lbc_host
`default_nettype wire

// >>> verif/lbc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Handshake and spacing checks on the host's command pins.
module lbc_host_properties
   import lbc_pkg::*;
#(
   parameter int ADDR_W = 13
)(
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              reqValid,
   input wire logic              reqReady,
   input wire logic              reqReject,
   input wire logic              memCke,
   input wire logic              memCsN,
   input wire logic              memRasN,
   input wire logic              memCasN,
   input wire logic              memWeN,
   input wire logic [1:0]        memBa,
   input wire logic [ADDR_W-1:0] memAddr
);
   logic [3:0] pins;

   // Command code in the order chip select, row, column, write.
   assign pins = {memCsN, memRasN, memCasN, memWeN};

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Issued activate, single-bank precharge, refresh and read commands.
   sequence sAct;
      reqReady && pins == CMD_ACTIVATE;
   endsequence
   sequence sPre;
      reqReady && pins == CMD_PRECHARGE && !memAddr[10];
   endsequence
   sequence sRef;
      reqReady && pins == CMD_REFRESH;
   endsequence
   sequence sRead;
      reqReady && pins == CMD_READ;
   endsequence

   reset_idle_a: assert property (disable iff (1'b0)
      rst |=> memCsN && !memCke && !reqReady && !reqReject) else $error("reset pins");
   cke_wait_a: assert property ($rose(memCke) |-> !reqReady [*3])
      else $error("early request");
   answer_time_a: assert property ($rose(reqValid) |=> reqReady || reqReject)
      else $error("late answer");
   issue_code_a: assert property (reqReady |-> !memCsN && pins != CMD_NOP)
      else $error("ready without command");
   act_delay_a: assert property (sAct |=> !(reqReady && memBa == $past(memBa) &&
      (pins == CMD_READ || pins == CMD_WRITE))) else $error("access too soon");
   pre_delay_a: assert property (sPre |=> !(reqReady && pins == CMD_ACTIVATE &&
      memBa == $past(memBa))) else $error("activate too soon");
   refresh_quiet_a: assert property (sRef |=> (pins == CMD_NOP) [*5])
      else $error("command during refresh");
   wr_after_rd_a: assert property (sRead |=> (pins != CMD_WRITE) [*3])
      else $error("write over read data");
endmodule : lbc_host_properties

bind lbc_host lbc_host_properties #(.ADDR_W(ADDR_W)) u_props (.ref_clk, .rst, .reqValid,
   .reqReady, .reqReject, .memCke, .memCsN, .memRasN, .memCasN, .memWeN, .memBa, .memAddr);
`default_nettype wire

// >>> verif/lbc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Bank state tracker standing in for the memory; counts illegal commands.
module lbc_dev_model
   import lbc_pkg::*;
#(
   parameter int ADDR_W = 13
)(
   input wire logic              ref_clk,
   input wire logic              memCke,
   input wire logic              memCsN,
   input wire logic              memRasN,
   input wire logic              memCasN,
   input wire logic              memWeN,
   input wire logic [1:0]        memBa,
   input wire logic [ADDR_W-1:0] memAddr,
   output var int                violations
);
   int   now     = 0;
   int   allRdy  = 0;
   int   rdy[4]  = '{default: 0};
   bit   open[4] = '{default: 0};
   logic ckePrev = 1'h0;

   // The count starts clean.
   initial violations = 0;

   // One command is registered per rising edge; idle codes leave banks as they are.
   always @(posedge ref_clk) begin : decode
      int         b;
      bit         idle;
      logic [3:0] c;
      b = int'(memBa);
      c = {memCsN, memRasN, memCasN, memWeN};
      idle = 1'h1;
      for (int i = 0; i < 4; i++) begin
         idle &= !open[i] && now >= rdy[i];
      end
      if (memCke && ckePrev && !memCsN && c != CMD_NOP) begin
         violations += int'(now < allRdy);
         case (c)
            CMD_ACTIVATE: begin
               violations += int'(open[b] || now < rdy[b]);
               open[b] = 1'h1;
               rdy[b] = now + CYC_RCD;
            end
            CMD_READ, CMD_WRITE: begin
               violations += int'(!open[b] || now < rdy[b]);
               if (memAddr[10]) begin
                  open[b] = 1'h0;
                  rdy[b] = now + CYC_RP + ((c == CMD_READ) ? BURST_CYC : WRITE_END + CYC_WR);
               end
            end
            CMD_PRECHARGE: begin
               for (int i = 0; i < 4; i++) begin
                  if (memAddr[10] || i == b) begin
                     violations += int'(now < rdy[i]);
                     open[i] = 1'h0;
                     rdy[i] = now + CYC_RP;
                  end
               end
            end
            CMD_REFRESH, CMD_MODE_LOAD: begin
               violations += int'(!idle);
               allRdy = now + ((c == CMD_REFRESH) ? CYC_RFC : CYC_MRD);
            end
            default: begin
            end
         endcase
      end
      ckePrev = memCke;
      now++;
   end
endmodule : lbc_dev_model
`default_nettype wire

// >>> verif/lbc_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Request scenarios checked against a reference model of the bank timers.
module lbc_host_bench;
   import lbc_pkg::*;
   localparam logic [3:0] PIN[8] = '{CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD, CMD_TERMINATE};
   logic        ref_clk = 1'h0, rst = 1'h1, reqValid = 1'h0, reqAutoPre = 1'h0;
   logic [2:0]  reqCmd = 3'h0;
   logic [1:0]  reqBank = 2'h0;
   logic [12:0] reqAddr = 13'h0;
   logic        reqReady, reqReject, memCke, memCsN, memRasN, memCasN, memWeN, memDmMask;
   logic [1:0]  memBa;
   logic [12:0] memAddr;
   int          fails = 0, compares = 0, cyc = 0, violations, seed = 32'h3763b04a;
   int          busy[4] = '{default: 0}, allUntil = 0, rdUntil = 0, apUntil = 0, wrUntil = 0;
   bit          open[4] = '{default: 0};

   always #10 ref_clk = ~ref_clk;

   // Edges since reset release are the model's time base.
   always @(posedge ref_clk) cyc <= rst ? 0 : cyc + 1;

   lbc_host #(.BANKS(4), .ADDR_W(13)) uut (.ref_clk, .rst, .reqValid, .reqCmd, .reqBank,
      .reqAddr, .reqAutoPre, .reqReady, .reqReject, .memCke, .memCsN, .memRasN, .memCasN,
      .memWeN, .memBa, .memAddr, .memDmMask);
   lbc_dev_model #(.ADDR_W(13)) dev (.ref_clk, .memCke, .memCsN, .memRasN, .memCasN,
      .memWeN, .memBa, .memAddr, .violations);

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (exp !== got) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // Presents one request, predicts its fate, then checks answer and pins.
   task automatic issue(input int cmd, input int b, input bit ap, input int gap);
      int          t;
      bit          ok, settled, idle;
      logic [12:0] addr;
      // A gap releases the request; no gap holds it up into the next one.
      if (gap > 0) begin
         reqValid <= 1'h0;
         repeat (gap) @(posedge ref_clk);
      end
      t = cyc;
      settled = 1'h1;
      idle = 1'h1;
      for (int i = 0; i < 4; i++) begin
         settled &= t >= busy[i];
         idle &= !open[i];
      end
      ok = t > CYC_XP && t >= allUntil;
      case (cmd)
         0: ok &= !open[b] && t >= busy[b];
         1, 2: ok &= open[b] && t >= busy[b] && t >= apUntil && (cmd == 1 || t >= rdUntil);
         3: ok &= t >= busy[b];
         4: ok &= settled && t >= apUntil;
         5, 6: ok &= idle && settled && t >= rdUntil;
         default: ;
      endcase
      addr = 13'($random(seed));
      reqValid <= 1'h1;
      reqCmd <= 3'(cmd);
      reqBank <= 2'(b);
      reqAutoPre <= ap;
      reqAddr <= addr;
      repeat (10) begin
         @(posedge ref_clk);
         if (reqReady === 1'h1 || reqReject === 1'h1) break;
      end
      chk("accepted", 16'(ok), 16'(reqReady));
      chk("answered", 16'h1, 16'(reqReady | reqReject));
      if (reqReady === 1'h1) begin
         chk("command", 16'(PIN[cmd]), 16'({memCsN, memRasN, memCasN, memWeN}));
         if (cmd < 4) chk("bank", 16'(b), 16'(memBa));
         if (cmd inside {[1:4]}) chk("apBit", 16'(cmd == 4 || (cmd < 3 && ap)), 16'(memAddr[10]));
         if (cmd == 0 || cmd == 6) chk("address", 16'(addr), 16'(memAddr));
         chk("dmMask", 16'(cmd == 1 && t < wrUntil), 16'(memDmMask));
         case (cmd)
            0: begin
               open[b] = 1'h1;
               busy[b] = t + CYC_RCD;
            end
            1, 2: begin
               if (cmd == 1) rdUntil = t + READ_LAT + BURST_CYC;
               if (cmd == 2) wrUntil = t + WRITE_END;
               if (ap) begin
                  open[b] = 1'h0;
                  apUntil = t + ((cmd == 1) ? BURST_CYC : WRITE_END + CYC_WR);
                  busy[b] = apUntil + CYC_RP;
               end
            end
            3: begin
               open[b] = 1'h0;
               busy[b] = t + CYC_RP;
            end
            4: begin
               open = '{default: 0};
               allUntil = t + CYC_RP;
            end
            5: allUntil = t + CYC_RFC;
            6: allUntil = t + CYC_MRD;
            default: rdUntil = t;
         endcase
      end
   endtask : issue

   // Directed sequence first, then random traffic with settled timers.
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      issue(0, 0, 0, 0);
      issue(0, 0, 0, 10);
      issue(0, 1, 0, 0);
      issue(1, 0, 0, 0);
      issue(7, 0, 0, 0);
      issue(1, 1, 0, 0);
      issue(2, 1, 0, 0);
      issue(2, 0, 1, 10);
      issue(1, 1, 0, 0);
      issue(1, 0, 0, 10);
      issue(5, 0, 0, 0);
      issue(2, 1, 0, 0);
      issue(1, 1, 0, 0);
      issue(3, 1, 0, 0);
      issue(5, 0, 0, 10);
      issue(0, 2, 0, 0);
      issue(6, 0, 0, 10);
      issue(0, 3, 0, 10);
      issue(4, 0, 0, 1);
      repeat (24) issue($unsigned($random(seed)) % 7, $unsigned($random(seed)) % 4,
         1'($random(seed)), 10);
      reqValid <= 1'h0;
      repeat (2) @(posedge ref_clk);
      chk("violations", 16'h0, 16'(violations));
      tally_and_finish();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (3000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end
endmodule : lbc_host_bench
`default_nettype wire
